// file: logic/usdrx_pkg.sv
// constants and types shared by the start-detect multi-drop receiver
package usdrx_pkg;

   // register index on the plain register port
   localparam logic [3:0]  ADDR_DATA    = 4'h0;
   localparam logic [3:0]  ADDR_STATUS  = 4'h1;
   localparam logic [3:0]  ADDR_CONTROL = 4'h2;
   localparam logic [3:0]  ADDR_DIVISOR = 4'h3;

   // status register bit positions
   localparam int STAT_FILTER      = 0;
   localparam int STAT_DOUBLE      = 1;
   localparam int STAT_FRAME_ERR   = 4;
   localparam int STAT_START_FLAG  = 5;
   localparam int STAT_TX_COMPLETE = 6;
   localparam int STAT_RX_COMPLETE = 7;

   // control register bit positions
   localparam int CTL_RX_ENABLE   = 0;
   localparam int CTL_RX_NINTH    = 1;
   localparam int CTL_TX_NINTH    = 2;
   localparam int CTL_SIZE_LSB    = 3;
   localparam int CTL_SFD_ENABLE  = 6;
   localparam int CTL_START_IRQ   = 7;
   localparam int CTL_SYNC_MODE   = 8;

   // character size codes: 0..3 give 5..8 bits, 7 gives 9 bits
   localparam logic [2:0]  SIZE_NINE    = 3'h7;
   localparam logic [3:0]  SIZE_BASE    = 4'h5;
   localparam logic [3:0]  BITS_NINE    = 4'h9;
   localparam logic [3:0]  SHIFT_WIDTH  = 4'h9;

   // sample states per bit and majority window start
   localparam logic [4:0]  SAMPLES_NORMAL = 5'h10;
   localparam logic [4:0]  SAMPLES_DOUBLE = 5'h08;
   localparam logic [4:0]  VOTE_FIRST_NORMAL = 5'h08;
   localparam logic [4:0]  VOTE_FIRST_DOUBLE = 5'h04;

   // values after reset
   localparam logic [2:0]  RESET_SIZE    = 3'h3;
   localparam logic [11:0] RESET_DIVISOR = 12'h000;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b11,
      RX_STOP  = 2'b10
   } usdrx_state_t;

   typedef struct packed {
      logic         lineMeta;
      logic         lineSync;
      logic         linePrev;
      logic         xckMeta;
      logic         xckSync;
      logic         xckPrev;
      logic         armed;
      usdrx_state_t state;
      logic [11:0]  prescale;
      logic [4:0]   samp;
      logic [3:0]   bitIdx;
      logic [2:0]   vote;
      logic [8:0]   shift;
      logic [7:0]   data;
      logic         ninth;
      logic         frameErr;
      logic         rxComplete;
      logic         startFlag;
      logic         txComplete;
      logic         filter;
      logic         dbl;
      logic         rxEn;
      logic         txNinth;
      logic [2:0]   charSize;
      logic         start_detect_enable;
      logic         startIrqEn;
      logic         syncMode;
      logic [11:0]  divisor;
      logic         oscRun;
      logic         portClk;
      logic         wake;
      logic         startIrq;
      logic [15:0]  rdata;
   } usdrx_regs_t;

endpackage

// file: logic/usdrx_receiver.sv
// receiver with start-frame wake detection and multi-drop address filter
// Functional notes
// - a start bit on the line wakes the core from deep sleep
// - falling line edge powers the 8 MHz oscillator and port clock
// - detection works async and sync, only while its enable is set
// - with start interrupt enabled, flag it at once on start detection
// - without it, only oscillator and port clock run until frame completes
// - while filtering, frames without address marking are dropped
// - the transmitter ignores the filter setting
// - frame type from first stop bit, or ninth bit for 9-bit frames
// - frame type one means address, zero means data
// - address frame under filtering is buffered and flags completion
// - transmitter and receiver share one character size setting
// - 16 sample states per bit normally, eight in double speed
// - frame error set when the first stop bit of a stored frame reads low (three-sample vote async, single sample sync)
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

module usdrx_receiver #(
   parameter int DIV_WIDTH = 12
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [15:0] regWdata,
   input  wire logic        regWrite,
   input  wire logic        regRead,
   output logic      [15:0] regRdata,
   // serial pins
   input  wire logic        serialReceiveLine,
   input  wire logic        syncClockIn,
   // power management
   input  wire logic        sleeping,
   output logic             oscRun,
   output logic             portClockRun,
   output logic             wakeRequest,
   output logic             rxStartIrq,
   // transmitter side
   input  wire logic        txDone,
   output logic      [2:0]  txCharSize,
   output logic             txNinthBit
);

   usdrx_pkg::usdrx_regs_t r_q;
   usdrx_pkg::usdrx_regs_t r_d;

   logic                    tick;
   logic                    lineFell;
   logic                    xckRose;
   logic [3:0]              nBits;
   logic [4:0]              sampLast;
   logic [4:0]              voteFirst;
   logic [4:0]              voteLast;
   logic                    inVote;
   logic                    decide;
   logic                    bitVal;
   logic                    finish;
   logic                    stopBit;
   logic [8:0]              assembled;
   logic                    frameType;
   logic [DIV_WIDTH-1:0]    divLimit;
   logic [11:0]             divReload;
   logic                    startSeen;

   assign divLimit = r_q.divisor[DIV_WIDTH-1:0];

   always_comb begin
      r_d = r_q;
      finish = 1'b0;
      stopBit = 1'b1;
      bitVal = 1'b0;
      assembled = 9'h000;
      frameType = 1'b0;

      // two-flop synchronisers for the pins
      r_d.lineMeta = serialReceiveLine;
      r_d.lineSync = r_q.lineMeta;
      r_d.linePrev = r_q.lineSync;
      r_d.xckMeta  = syncClockIn;
      r_d.xckSync  = r_q.xckMeta;
      r_d.xckPrev  = r_q.xckSync;
      lineFell = r_q.linePrev & ~r_q.lineSync;
      xckRose  = r_q.xckSync & ~r_q.xckPrev;

      // one character size serves both directions
      nBits = (r_q.charSize == usdrx_pkg::SIZE_NINE) ?
              usdrx_pkg::BITS_NINE :
              usdrx_pkg::SIZE_BASE + {1'b0, r_q.charSize};

      // sample clock from the divisor
      tick = (r_q.prescale == 12'h000);
      // reload keeps unused high divisor bits at zero
      divReload = 12'h000;
      divReload[DIV_WIDTH-1:0] = divLimit;
      r_d.prescale = tick ? divReload : r_q.prescale - 12'h001;

      if (r_q.dbl) begin
         sampLast  = usdrx_pkg::SAMPLES_DOUBLE;
         voteFirst = usdrx_pkg::VOTE_FIRST_DOUBLE;
      end else begin
         sampLast  = usdrx_pkg::SAMPLES_NORMAL;
         voteFirst = usdrx_pkg::VOTE_FIRST_NORMAL;
      end
      voteLast  = voteFirst + 5'h02;
      inVote    = (r_q.samp >= voteFirst) && (r_q.samp <= voteLast);
      decide    = tick && (r_q.samp == voteLast);

      // majority of the three centre samples
      if (decide) begin
         bitVal = (r_q.vote[1] & r_q.vote[0]) |
                  (r_q.vote[1] & r_q.lineSync) |
                  (r_q.vote[0] & r_q.lineSync);
      end

      if (!r_q.rxEn) begin
         r_d.state = usdrx_pkg::RX_IDLE;
         r_d.armed = 1'b0;
      end else if (r_q.syncMode) begin
         // synchronous: one decision per rising port clock
         if (xckRose) begin
            unique case (r_q.state)
               usdrx_pkg::RX_IDLE: begin
                  if (!r_q.lineSync) begin
                     r_d.state  = usdrx_pkg::RX_DATA;
                     r_d.bitIdx = 4'h0;
                  end
               end
               usdrx_pkg::RX_START: begin
                  r_d.state = usdrx_pkg::RX_DATA;
               end
               usdrx_pkg::RX_DATA: begin
                  r_d.shift  = {r_q.lineSync, r_q.shift[8:1]};
                  r_d.bitIdx = r_q.bitIdx + 4'h1;
                  if (r_q.bitIdx + 4'h1 == nBits) begin
                     r_d.state = usdrx_pkg::RX_STOP;
                  end
               end
               usdrx_pkg::RX_STOP: begin
                  finish  = 1'b1;
                  stopBit = r_q.lineSync;
                  r_d.state = usdrx_pkg::RX_IDLE;
               end
            endcase
         end
      end else if (tick) begin
         // asynchronous: sample states within each bit
         if (inVote) begin
            r_d.vote = {r_q.vote[1:0], r_q.lineSync};
         end
         r_d.samp = (r_q.samp == sampLast) ? 5'h01 : r_q.samp + 5'h01;
         unique case (r_q.state)
            usdrx_pkg::RX_IDLE: begin
               r_d.samp = 5'h01;
               // a start counts only after an idle-high tick
               if (r_q.lineSync) begin
                  r_d.armed = 1'b1;
               end else if (r_q.armed) begin
                  r_d.state = usdrx_pkg::RX_START;
                  r_d.samp  = 5'h02;
                  r_d.armed = 1'b0;
               end
            end
            usdrx_pkg::RX_START: begin
               // majority high means a noise spike: hunt again
               if (decide && bitVal) begin
                  r_d.state = usdrx_pkg::RX_IDLE;
               end else if (r_q.samp == sampLast) begin
                  r_d.state  = usdrx_pkg::RX_DATA;
                  r_d.bitIdx = 4'h0;
               end
            end
            usdrx_pkg::RX_DATA: begin
               if (decide) begin
                  r_d.shift  = {bitVal, r_q.shift[8:1]};
                  r_d.bitIdx = r_q.bitIdx + 4'h1;
               end
               if (r_q.samp == sampLast && r_q.bitIdx == nBits) begin
                  r_d.state = usdrx_pkg::RX_STOP;
               end
            end
            usdrx_pkg::RX_STOP: begin
               // next start may follow right after the vote
               if (decide) begin
                  finish  = 1'b1;
                  stopBit = bitVal;
                  r_d.state = usdrx_pkg::RX_IDLE;
               end
            end
         endcase
      end

      // start-frame detection while asleep
      startSeen = r_q.start_detect_enable & sleeping & lineFell;
      if (startSeen) begin
         r_d.oscRun  = 1'b1;
         r_d.portClk = 1'b1;
      end
      // awake core runs its own clocks
      if (!sleeping) begin
         r_d.oscRun  = 1'b0;
         r_d.portClk = 1'b0;
      end

      // register writes; clears come before hardware sets
      if (regWrite) begin
         unique case (regAddr)
            usdrx_pkg::ADDR_STATUS: begin
               // filter written whole-register only
               r_d.filter = regWdata[usdrx_pkg::STAT_FILTER];
               r_d.dbl    = regWdata[usdrx_pkg::STAT_DOUBLE];
               if (regWdata[usdrx_pkg::STAT_START_FLAG]) begin
                  r_d.startFlag = 1'b0;
               end
               if (regWdata[usdrx_pkg::STAT_TX_COMPLETE]) begin
                  r_d.txComplete = 1'b0;
               end
            end
            usdrx_pkg::ADDR_CONTROL: begin
               r_d.rxEn       = regWdata[usdrx_pkg::CTL_RX_ENABLE];
               r_d.txNinth    = regWdata[usdrx_pkg::CTL_TX_NINTH];
               r_d.charSize   =
                  regWdata[usdrx_pkg::CTL_SIZE_LSB +: 3];
               r_d.start_detect_enable      = regWdata[usdrx_pkg::CTL_SFD_ENABLE];
               r_d.startIrqEn = regWdata[usdrx_pkg::CTL_START_IRQ];
               r_d.syncMode   = regWdata[usdrx_pkg::CTL_SYNC_MODE];
            end
            usdrx_pkg::ADDR_DIVISOR: begin
               r_d.divisor = regWdata[11:0];
            end
            default: begin
            end
         endcase
      end

      // register reads, answered one cycle later
      r_d.rdata = 16'h0000;
      if (regRead) begin
         unique case (regAddr)
            usdrx_pkg::ADDR_DATA: begin
               r_d.rdata = {8'h00, r_q.data};
               // reading the data word acknowledges the frame
               r_d.rxComplete = 1'b0;
            end
            usdrx_pkg::ADDR_STATUS: begin
               r_d.rdata[usdrx_pkg::STAT_FILTER]      = r_q.filter;
               r_d.rdata[usdrx_pkg::STAT_DOUBLE]      = r_q.dbl;
               r_d.rdata[usdrx_pkg::STAT_FRAME_ERR]   = r_q.frameErr;
               r_d.rdata[usdrx_pkg::STAT_START_FLAG]  = r_q.startFlag;
               r_d.rdata[usdrx_pkg::STAT_TX_COMPLETE] = r_q.txComplete;
               r_d.rdata[usdrx_pkg::STAT_RX_COMPLETE] = r_q.rxComplete;
            end
            usdrx_pkg::ADDR_CONTROL: begin
               r_d.rdata[usdrx_pkg::CTL_RX_ENABLE]  = r_q.rxEn;
               r_d.rdata[usdrx_pkg::CTL_RX_NINTH]   = r_q.ninth;
               r_d.rdata[usdrx_pkg::CTL_TX_NINTH]   = r_q.txNinth;
               r_d.rdata[usdrx_pkg::CTL_SIZE_LSB +: 3] = r_q.charSize;
               r_d.rdata[usdrx_pkg::CTL_SFD_ENABLE] = r_q.start_detect_enable;
               r_d.rdata[usdrx_pkg::CTL_START_IRQ]  = r_q.startIrqEn;
               r_d.rdata[usdrx_pkg::CTL_SYNC_MODE]  = r_q.syncMode;
            end
            usdrx_pkg::ADDR_DIVISOR: begin
               r_d.rdata = {4'h0, r_q.divisor};
            end
            default: begin
            end
         endcase
      end

      // hardware sets win over same-cycle clears
      if (txDone) begin
         r_d.txComplete = 1'b1;
      end
      if (startSeen && r_q.startIrqEn) begin
         r_d.startFlag = 1'b1;
      end

      // frame completion and multi-drop filter
      if (finish) begin
         assembled = r_q.shift >> (usdrx_pkg::SHIFT_WIDTH - nBits);
         frameType = (nBits == usdrx_pkg::BITS_NINE) ?
                     assembled[8] : stopBit;
         // the filter never reaches the transmitter outputs
         if (!r_q.filter || frameType) begin
            r_d.data       = assembled[7:0];
            r_d.ninth      = assembled[8] &
                             (nBits == usdrx_pkg::BITS_NINE);
            // error kept only for frames that are stored
            r_d.frameErr   = ~stopBit;
            r_d.rxComplete = 1'b1;
         end
      end

      // clocks stay only until the frame ends without start irq
      if (r_q.oscRun && !r_q.startIrqEn &&
          r_q.state != usdrx_pkg::RX_IDLE &&
          r_d.state == usdrx_pkg::RX_IDLE) begin
         r_d.oscRun  = 1'b0;
         r_d.portClk = 1'b0;
      end
      // enable from this cycle's write, so the irq follows it at once
      r_d.startIrq = r_d.startFlag & r_d.startIrqEn;
      // wake only while asleep; an awake core polls the flags
      r_d.wake = sleeping &
                 (r_d.startIrq | r_d.rxComplete);
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r_q <= '0;
         // line synchronisers start idle high, so no false edge
         r_q.lineMeta <= 1'b1;
         r_q.lineSync <= 1'b1;
         r_q.linePrev <= 1'b1;
         r_q.state    <= usdrx_pkg::RX_IDLE;
         r_q.charSize <= usdrx_pkg::RESET_SIZE;
         r_q.divisor  <= usdrx_pkg::RESET_DIVISOR;
      end else begin
         r_q <= r_d;
      end
   end

   assign regRdata     = r_q.rdata;
   assign oscRun       = r_q.oscRun;
   assign portClockRun = r_q.portClk;
   assign wakeRequest  = r_q.wake;
   assign rxStartIrq   = r_q.startIrq;
   assign txCharSize   = r_q.charSize;
   assign txNinthBit   = r_q.txNinth;

endmodule // usdrx_receiver

// file: testbench/usdrx_monitor.sv
// assertion checker for the start-detect multi-drop receiver
`timescale 1ns/1ps

module usdrx_monitor #(
   parameter int DIV_WIDTH = 12
) (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // register port
   input wire logic [3:0]  regAddr,
   input wire logic [15:0] regWdata,
   input wire logic        regWrite,
   input wire logic        regRead,
   input wire logic [15:0] regRdata,
   // serial pins
   input wire logic        serialReceiveLine,
   input wire logic        syncClockIn,
   // power management
   input wire logic        sleeping,
   input wire logic        oscRun,
   input wire logic        portClockRun,
   input wire logic        wakeRequest,
   input wire logic        rxStartIrq,
   // transmitter side
   input wire logic        txDone,
   input wire logic [2:0]  txCharSize,
   input wire logic        txNinthBit
);
   logic [15:0] lastWdata_q;

   always_ff @(posedge clk) begin
      lastWdata_q <= regWdata;
   end

   default clocking mcb @(posedge clk); endclocking
   default disable iff (reset);

   AST_CLOCK_PAIR: assert property (oscRun == portClockRun)
      else $error("oscillator and port clock requests differ");
   AST_OSC_ON_FALL: assert property ($rose(oscRun)
      |-> sleeping && !serialReceiveLine)
      else $error("oscillator started without a start bit");
   AST_AWAKE_NO_OSC: assert property (!sleeping [*2] |-> !oscRun)
      else $error("oscillator kept running while awake");
   AST_AWAKE_NO_WAKE: assert property (!sleeping [*2] |-> !wakeRequest)
      else $error("wake request while awake");
   AST_IRQ_HOLDS: assert property ($fell(rxStartIrq) |-> $past(regWrite))
      else $error("start interrupt dropped without a write");
   AST_IRQ_CAUSE: assert property ($rose(rxStartIrq)
      |-> $past(regWrite) || (sleeping && !serialReceiveLine))
      else $error("start interrupt without a start bit");
   AST_SIZE_HOLDS: assert property ($changed(txCharSize)
      |-> $past(reset) || ($past(regWrite)
          && $past(regAddr) == usdrx_pkg::ADDR_CONTROL))
      else $error("character size changed without a control write");
   AST_SIZE_VALUE: assert property (regWrite
      && regAddr == usdrx_pkg::ADDR_CONTROL
      |=> txCharSize == lastWdata_q[5:3])
      else $error("character size differs from written control");
   AST_NINTH_VALUE: assert property (regWrite
      && regAddr == usdrx_pkg::ADDR_CONTROL
      |=> txNinthBit == lastWdata_q[2])
      else $error("transmit ninth bit differs from written control");
endmodule // usdrx_monitor

bind usdrx_receiver usdrx_monitor #(.DIV_WIDTH(DIV_WIDTH)) u_monitor (
   .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
   .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
   .serialReceiveLine(serialReceiveLine), .syncClockIn(syncClockIn),
   .sleeping(sleeping), .oscRun(oscRun), .portClockRun(portClockRun),
   .wakeRequest(wakeRequest), .rxStartIrq(rxStartIrq), .txDone(txDone),
   .txCharSize(txCharSize), .txNinthBit(txNinthBit)
);

// file: testbench/usdrx_far_tx.sv
// far-side serial transmitter model for the multi-drop receiver
`timescale 1ns/1ps

module usdrx_far_tx (
   // clock
   input  wire logic clk,
   // serial pins
   output logic      line,
   output logic      syncClk
);
   // idle high, port clock still outside frames
   initial begin
      line = 1'b1;
      syncClk = 1'b0;
   end

   // exact bit time, so no rate error at all
   task automatic put_bit(input logic b, input int clks, input logic sync);
      line <= b;
      repeat (clks / 2) @(posedge clk);
      syncClk <= sync; // one rise per bit, well under a quarter clock
      repeat (clks - clks / 2) @(posedge clk);
      syncClk <= 1'b0;
   endtask

   // lsb first; a 9-bit address sets the ninth bit
   task automatic send(input logic [8:0] data, input int nBits,
                       input logic firstStop, input int clks,
                       input logic sync);
      put_bit(1'b0, clks, sync);
      for (int i = 0; i < nBits; i++) put_bit(data[i], clks, sync);
      put_bit(firstStop, clks, sync);
      put_bit(1'b1, clks, sync); // second stop bit
   endtask
endmodule // usdrx_far_tx

// file: testbench/usdrx_receiver_test.sv
// self-checking bench for the start-detect multi-drop receiver
`timescale 1ns/1ps

module usdrx_receiver_test;
   localparam int BIT_CLKS  = 32;
   localparam int SYNC_CLKS = 500;
   localparam int LIMIT     = 30000;

   logic        clk;
   logic        reset;
   logic [3:0]  regAddr;
   logic [15:0] regWdata;
   logic        regWrite;
   logic        regRead;
   logic [15:0] regRdata;
   logic        serialReceiveLine;
   logic        syncClockIn;
   logic        sleeping;
   logic        oscRun;
   logic        portClockRun;
   logic        wakeRequest;
   logic        rxStartIrq;
   logic        txDone;
   logic [2:0]  txCharSize;
   logic        txNinthBit;
   logic [15:0] rd;
   int          miscompares = 0;
   int          n_compared = 0;
   int          cycles = 0;

   usdrx_receiver #(.DIV_WIDTH(12)) dut (
      .clk(clk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
      .serialReceiveLine(serialReceiveLine), .syncClockIn(syncClockIn),
      .sleeping(sleeping), .oscRun(oscRun), .portClockRun(portClockRun),
      .wakeRequest(wakeRequest), .rxStartIrq(rxStartIrq), .txDone(txDone),
      .txCharSize(txCharSize), .txNinthBit(txNinthBit));
   usdrx_far_tx u_far (.clk(clk), .line(serialReceiveLine),
      .syncClk(syncClockIn));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end

   task automatic summarize();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      regWrite <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask

   task automatic rdreg(input logic [3:0] a);
      @(posedge clk);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      #1 rd = regRdata;
   endtask

   task automatic stat(input int pos, input logic exp);
      rdreg(usdrx_pkg::ADDR_STATUS);
      chk({15'h0000, rd[pos]}, {15'h0000, exp});
   endtask

   task automatic frame(input logic [8:0] d, input int n, input logic stop,
                        input int clks, input logic sync);
      u_far.send(d, n, stop, clks, sync);
      repeat (4) @(posedge clk);
   endtask

   task automatic wake(input logic [15:0] ctl, input int clks,
                       input logic sync, input logic expOsc,
                       input logic expIrq);
      wr(usdrx_pkg::ADDR_CONTROL, ctl);
      sleeping <= 1'b1;
      fork
         frame(9'h05A, 8, 1'b1, clks, sync);
         begin
            repeat (clks / 2) @(posedge clk);
            chk({14'h0, oscRun, rxStartIrq}, {14'h0, expOsc, expIrq});
         end
      join
      chk({14'h0, oscRun, wakeRequest}, {14'h0, expOsc & expIrq, 1'b1});
      sleeping <= 1'b0;
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h005A);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0020);
      #1;
      chk({15'h0, rxStartIrq}, 16'h0000);
   endtask

   initial begin
      reset = 1'b1;
      regAddr = 4'h0;
      regWdata = 16'h0000;
      regWrite = 1'b0;
      regRead = 1'b0;
      sleeping = 1'b0;
      txDone = 1'b0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      rdreg(usdrx_pkg::ADDR_CONTROL);
      chk(rd, 16'h0018);
      rdreg(usdrx_pkg::ADDR_STATUS);
      chk(rd, 16'h0000);
      wr(4'hF, 16'hFFFF);
      rdreg(4'hF);
      chk(rd, 16'h0000);
      chk({13'h0, txCharSize}, 16'h0003);
      wr(usdrx_pkg::ADDR_DIVISOR, 16'h0001);
      rdreg(usdrx_pkg::ADDR_DIVISOR);
      chk(rd, 16'h0001);
      wr(usdrx_pkg::ADDR_CONTROL, 16'h0019);
      frame(9'h0A5, 8, 1'b1, BIT_CLKS, 1'b0);
      stat(usdrx_pkg::STAT_RX_COMPLETE, 1'b1);
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h00A5);
      stat(usdrx_pkg::STAT_RX_COMPLETE, 1'b0);
      frame(9'h055, 8, 1'b0, BIT_CLKS, 1'b0);
      stat(usdrx_pkg::STAT_FRAME_ERR, 1'b1);
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h0055);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0001); // whole word
      frame(9'h011, 8, 1'b0, BIT_CLKS, 1'b0);
      stat(usdrx_pkg::STAT_RX_COMPLETE, 1'b0);
      frame(9'h022, 8, 1'b1, BIT_CLKS, 1'b0);
      stat(usdrx_pkg::STAT_FRAME_ERR, 1'b0);
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h0022);
      wr(usdrx_pkg::ADDR_CONTROL, 16'h003D);
      #1;
      chk({12'h0, txNinthBit, txCharSize}, 16'h000F);
      @(posedge clk);
      txDone <= 1'b1;
      @(posedge clk);
      txDone <= 1'b0;
      stat(usdrx_pkg::STAT_TX_COMPLETE, 1'b1);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0041);
      stat(usdrx_pkg::STAT_TX_COMPLETE, 1'b0);
      frame(9'h033, 9, 1'b1, BIT_CLKS, 1'b0);
      stat(usdrx_pkg::STAT_RX_COMPLETE, 1'b0);
      frame(9'h1AB, 9, 1'b1, BIT_CLKS, 1'b0);
      rdreg(usdrx_pkg::ADDR_CONTROL);
      chk({15'h0, rd[1]}, 16'h0001);
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h00AB);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0000); // selected
      frame(9'h0CD, 9, 1'b1, BIT_CLKS, 1'b0);
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h00CD);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0001); // last data seen
      frame(9'h0EE, 9, 1'b1, BIT_CLKS, 1'b0);
      stat(usdrx_pkg::STAT_RX_COMPLETE, 1'b0);
      wr(usdrx_pkg::ADDR_CONTROL, 16'h0019);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0002);
      frame(9'h03C, 8, 1'b1, BIT_CLKS / 2, 1'b0);
      rdreg(usdrx_pkg::ADDR_DATA);
      chk(rd, 16'h003C);
      wr(usdrx_pkg::ADDR_STATUS, 16'h0000);
      wake(16'h00D9, BIT_CLKS, 1'b0, 1'b1, 1'b1);
      wake(16'h0059, BIT_CLKS, 1'b0, 1'b1, 1'b0);
      wake(16'h0159, SYNC_CLKS, 1'b1, 1'b1, 1'b0);
      wake(16'h0019, BIT_CLKS, 1'b0, 1'b0, 1'b0);
      summarize();
   end
endmodule // usdrx_receiver_test
